// ### hdl/sccfg_pkg.sv
// shared constants of the star coupler configuration register block
package sccfg_pkg;

	// ==========================================================
	// serial frame layout
	localparam int FRAME_W = 16;
	localparam int CNT_W = 5;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 12;
	localparam int SYNC_W = 29;
	localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
	localparam logic [CNT_W-1:0] FRAME_MSB = 5'h0F;
	localparam logic [CNT_W-1:0] CNT_SAT = 5'h1F;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] ADDR_DONE = 5'h03;
	localparam int BIT_ADDR_HI = 15;
	localparam int BIT_ADDR_LO = 13;
	localparam int BIT_READ_ONLY = 12;

	// ==========================================================
	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_GEN = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_BR1 = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_BR2 = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_CFG = 3'h7;

	// ==========================================================
	// configuration field positions
	localparam int BIT_AEC = 11;
	localparam int BIT_BFT = 10;
	localparam int BIT_WAKE1 = 9;
	localparam int BIT_WAKE2 = 8;
	localparam int BIT_RSV_HI = 7;
	localparam int BIT_RSV_LO = 6;
	localparam int BIT_CTRL_IF = 5;
	localparam int BIT_CASCADE = 4;
	localparam int BIT_STUCK = 2;
	localparam int BIT_LATCH = 1;
	localparam logic [DATA_W-1:0] CFG_RESET = 12'h07D4;
	localparam logic [DATA_W-1:0] CFG_WMASK = 12'h0FF6;

	// ==========================================================
	// status registers and timing
	localparam int STAT_W = 11;
	localparam int N_STAT = 3;
	localparam int N_BRANCH = 2;
	localparam int CLK_MHZ = 250;
	localparam int FAIL_TIMER_NS = 1000;
	localparam int FAIL_TIMER_CYC = (FAIL_TIMER_NS * CLK_MHZ + 999) / 1000;

endpackage

// ### hdl/sccfg_link.sv
// serial-clock side of the host link: bit counter, shifter, address catch
module sccfg_link
(
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic mosi,
	output logic [sccfg_pkg::FRAME_W-1:0] rx_word,
	output logic [sccfg_pkg::CNT_W-1:0] cnt_gray,
	output logic [sccfg_pkg::ADDR_W-1:0] sel_addr
);
	import sccfg_pkg::*;

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [FRAME_W-1:0] shift_q;
	logic [CNT_W-1:0] gray_q;
	logic [ADDR_W-1:0] addr_q;

	// ==========================================================
	// sampling on the falling edge
	always_comb begin
		cnt_d = cnt_q;
		if (cnt_q != CNT_SAT) begin
			cnt_d = cnt_q + CNT_ONE;
		end
	end

	// deselect clears the count, since sclk may not run between frames
	always_ff @(negedge sclk or posedge serial_select_n) begin
		if (serial_select_n) begin
			cnt_q <= '0;
			gray_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			gray_q <= cnt_d ^ (cnt_d >> 1);
		end
	end

	always_ff @(negedge sclk) begin
		shift_q <= {shift_q[FRAME_W-2:0], mosi};
	end

	// address stays put after the third bit so the core can read it
	always_ff @(negedge sclk) begin
		if (cnt_q == ADDR_DONE - CNT_ONE) begin
			addr_q <= {shift_q[ADDR_W-2:0], mosi};
		end
	end

	assign rx_word = shift_q;
	assign cnt_gray = gray_q;
	assign sel_addr = addr_q;

endmodule

// ### hdl/sccfg_top.sv
// star coupler configuration register with serial host access
// Functional notes
// - error confinement sends faulted branch quiet
// - failure timer ignores short bus pulses
// - per-branch wake receiver enables, default on
// - controller interface off turns receive driver off
// - controller interface on passes transmit inputs
// - cascade interface enable, default on
// - stuck detection enable, default on
// - stuck condition raises clamp error when enabled
// - latching holds status until register read
// - status read releases latch to live
// - latching off shows live status always
// - bit zero makes odd parity
// - top three bits address, 111 is configuration
// - bit 12 low writes, high reads only
// - msb first, sample falling; host shifts mosi rising, miso moves after each fall
module sccfg_top #(
	parameter int unsigned FAIL_CYC = sccfg_pkg::FAIL_TIMER_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic [sccfg_pkg::N_BRANCH-1:0] branch_tx_fault,
	input wire logic [sccfg_pkg::N_BRANCH-1:0] branch_normal_cmd,
	output logic [sccfg_pkg::N_BRANCH-1:0] branch_quiet_state,
	input wire logic [sccfg_pkg::N_BRANCH-1:0] bus_active,
	output logic [sccfg_pkg::N_BRANCH-1:0] bus_fault,
	output logic wake_detect_branch_one,
	output logic wake_detect_branch_two,
	output logic [1:0] supply_trim,
	input wire logic ctl_txd,
	input wire logic ctl_tx_en,
	input wire logic star_rxd,
	output logic core_txd,
	output logic core_tx_en,
	output logic ctl_rxd,
	output logic ctl_rxd_oe,
	output logic cascade_if_en,
	input wire logic stuck_on_tx_enable,
	input wire logic stuck_on_cascade,
	input wire logic [sccfg_pkg::N_BRANCH-1:0] stuck_on_branch,
	output logic clamp_error,
	input wire logic [sccfg_pkg::STAT_W-1:0] gen_status_live,
	input wire logic [sccfg_pkg::STAT_W-1:0] br1_status_live,
	input wire logic [sccfg_pkg::STAT_W-1:0] br2_status_live,
	output logic [sccfg_pkg::STAT_W-1:0] gen_status_shown,
	output logic [sccfg_pkg::STAT_W-1:0] br1_status_shown,
	output logic [sccfg_pkg::STAT_W-1:0] br2_status_shown,
	output logic spi_error
);
	import sccfg_pkg::*;

	localparam int FT_W = $clog2(FAIL_CYC + 1);
	localparam logic [FT_W-1:0] FT_MAX = FT_W'(FAIL_CYC);
	localparam logic [FT_W-1:0] FT_ONE = FT_W'(1);

	logic [FRAME_W-1:0] rx_word;
	logic [CNT_W-1:0] cnt_gray;
	logic [ADDR_W-1:0] sel_addr;
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic cs_s;
	logic [CNT_W-1:0] gray_s;
	logic txd_s;
	logic txen_s;
	logic [N_BRANCH-1:0] act_s;
	logic [FRAME_W-1:0] rxw_s;
	logic [ADDR_W-1:0] addr_s;
	logic [CNT_W-1:0] cnt_bin;
	logic cs_prev_q;
	logic [CNT_W-1:0] frame_cnt_q;
	logic frame_end;
	logic frame_ok;
	logic [ADDR_W-1:0] rx_addr;
	logic cfg_write;
	logic [DATA_W-1:0] cfg_q;
	logic [STAT_W-1:0] rd_body;
	logic [FRAME_W-1:0] rd_word;
	logic [3:0] bit_idx;
	logic miso_q;
	logic miso_oe_q;
	logic spi_error_q;
	logic [N_BRANCH-1:0] quiet_q;
	logic [N_BRANCH-1:0] bus_fault_q;
	logic [FT_W-1:0] ft_cnt_q [N_BRANCH];
	logic core_txd_q;
	logic core_txen_q;
	logic ctl_rxd_q;
	logic ctl_rxd_oe_q;
	logic clamp_q;
	logic [STAT_W-1:0] live [N_STAT];
	logic [STAT_W-1:0] shown_q [N_STAT];
	logic [N_STAT-1:0] release_rd;

	function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
		logic [CNT_W-1:0] b;
		b = '0;
		for (int i = 0; i < CNT_W; i++) begin
			b[i] = ^(g >> i);
		end
		return b;
	endfunction

	// ==========================================================
	// link domain and crossing
	sccfg_link u_link (
		.sclk(sclk),
		.serial_select_n(serial_select_n),
		.mosi(mosi),
		.rx_word(rx_word),
		.cnt_gray(cnt_gray),
		.sel_addr(sel_addr)
	);

	// rx_word and sel_addr are still by the time the core reads them
	always_ff @(posedge clk) begin
		sync1_q <= {serial_select_n, cnt_gray, ctl_txd, ctl_tx_en,
			bus_active, sel_addr, rx_word};
		sync2_q <= sync1_q;
	end

	assign {cs_s, gray_s, txd_s, txen_s, act_s, addr_s, rxw_s} = sync2_q;
	assign cnt_bin = gray2bin(gray_s);

	// ==========================================================
	// frame completion
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cs_prev_q <= 1'b1;
			frame_cnt_q <= '0;
		end else begin
			cs_prev_q <= cs_s;
			// cleared count may arrive a clk before select: skip zeros
			if (frame_end) begin
				frame_cnt_q <= '0;
			end else if (!cs_s && cnt_bin != '0) begin
				frame_cnt_q <= cnt_bin;
			end
		end
	end

	assign frame_end = cs_s && !cs_prev_q;
	assign frame_ok = frame_end && (frame_cnt_q == FRAME_BITS);
	assign rx_addr = rxw_s[BIT_ADDR_HI:BIT_ADDR_LO];
	assign cfg_write = frame_ok && (rx_addr == ADDR_CFG)
		&& !rxw_s[BIT_READ_ONLY];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			spi_error_q <= 1'b0;
		end else begin
			spi_error_q <= frame_end && (frame_cnt_q != FRAME_BITS);
		end
	end

	// ==========================================================
	// configuration register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_q <= CFG_RESET;
		end else if (cfg_write) begin
			// masked bits keep reset zero: parity slot and bit 3
			cfg_q <= (cfg_q & ~CFG_WMASK)
				| (rxw_s[DATA_W-1:0] & CFG_WMASK);
		end
	end

	assign wake_detect_branch_one = cfg_q[BIT_WAKE1];
	assign wake_detect_branch_two = cfg_q[BIT_WAKE2];
	assign supply_trim = cfg_q[BIT_RSV_HI:BIT_RSV_LO];
	assign cascade_if_en = cfg_q[BIT_CASCADE];

	// ==========================================================
	// readback
	always_comb begin
		rd_body = '0;
		if (addr_s == ADDR_CFG) begin
			rd_body = cfg_q[DATA_W-1:1];
		end else if (addr_s == ADDR_GEN) begin
			rd_body = shown_q[0];
		end else if (addr_s == ADDR_BR1) begin
			rd_body = shown_q[1];
		end else if (addr_s == ADDR_BR2) begin
			rd_body = shown_q[2];
		end
	end

	assign rd_word = {{(FRAME_W - DATA_W){1'b0}}, rd_body, ~^rd_body};
	assign bit_idx = 4'(FRAME_MSB - cnt_bin);

	// next bit settles well inside the sclk low phase
	always_ff @(posedge clk) begin
		if (!nrst) begin
			miso_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end else begin
			miso_oe_q <= !cs_s;
			if (!cs_s && cnt_bin < FRAME_BITS) begin
				miso_q <= rd_word[bit_idx];
			end else begin
				miso_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// branch confinement and failure timer
	for (genvar b = 0; b < N_BRANCH; b++) begin : g_branch
		always_ff @(posedge clk) begin
			if (!nrst) begin
				quiet_q[b] <= 1'b0;
			end else if (cfg_q[BIT_AEC] && branch_tx_fault[b]) begin
				quiet_q[b] <= 1'b1;
			end else if (branch_normal_cmd[b]) begin
				quiet_q[b] <= 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			if (!nrst) begin
				ft_cnt_q[b] <= '0;
			end else if (!act_s[b]) begin
				ft_cnt_q[b] <= '0;
			end else if (ft_cnt_q[b] != FT_MAX) begin
				ft_cnt_q[b] <= ft_cnt_q[b] + FT_ONE;
			end
		end

		always_ff @(posedge clk) begin
			if (!nrst) begin
				bus_fault_q[b] <= 1'b0;
			end else begin
				bus_fault_q[b] <= act_s[b]
					&& (!cfg_q[BIT_BFT] || ft_cnt_q[b] == FT_MAX);
			end
		end
	end

	// ==========================================================
	// controller interface and clamp error
	always_ff @(posedge clk) begin
		if (!nrst) begin
			core_txd_q <= 1'b1;
			core_txen_q <= 1'b1;
			ctl_rxd_q <= 1'b1;
			ctl_rxd_oe_q <= 1'b0;
		end else begin
			// idle levels while off keep the star from seeing traffic
			core_txd_q <= !cfg_q[BIT_CTRL_IF] || txd_s;
			core_txen_q <= !cfg_q[BIT_CTRL_IF] || txen_s;
			ctl_rxd_q <= !cfg_q[BIT_CTRL_IF] || star_rxd;
			ctl_rxd_oe_q <= cfg_q[BIT_CTRL_IF];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			clamp_q <= 1'b0;
		end else begin
			clamp_q <= cfg_q[BIT_STUCK] && (stuck_on_tx_enable
				|| stuck_on_cascade || |stuck_on_branch);
		end
	end

	// ==========================================================
	// status latching
	assign live[0] = gen_status_live;
	assign live[1] = br1_status_live;
	assign live[2] = br2_status_live;
	assign release_rd[0] = frame_ok && rx_addr == ADDR_GEN;
	assign release_rd[1] = frame_ok && rx_addr == ADDR_BR1;
	assign release_rd[2] = frame_ok && rx_addr == ADDR_BR2;

	for (genvar k = 0; k < N_STAT; k++) begin : g_stat
		always_ff @(posedge clk) begin
			if (!nrst) begin
				shown_q[k] <= '0;
			end else if (!cfg_q[BIT_LATCH] || release_rd[k]) begin
				shown_q[k] <= live[k];
			end else begin
				shown_q[k] <= shown_q[k] | live[k];
			end
		end
	end

	assign miso = miso_q;
	assign miso_oe = miso_oe_q;
	assign branch_quiet_state = quiet_q;
	assign bus_fault = bus_fault_q;
	assign core_txd = core_txd_q;
	assign core_tx_en = core_txen_q;
	assign ctl_rxd = ctl_rxd_q;
	assign ctl_rxd_oe = ctl_rxd_oe_q;
	assign clamp_error = clamp_q;
	assign gen_status_shown = shown_q[0];
	assign br1_status_shown = shown_q[1];
	assign br2_status_shown = shown_q[2];
	assign spi_error = spi_error_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence seq_good_end;
		frame_end && frame_cnt_q == FRAME_BITS;
	endsequence

	sequence seq_cfg_write;
		seq_good_end ##0 (rx_addr == ADDR_CFG && !rxw_s[BIT_READ_ONLY]);
	endsequence

	AST_AEC_QUIET: assert property (cfg_q[BIT_AEC] && branch_tx_fault[0]
		|=> branch_quiet_state[0]) else $error("fault did not quiet branch");
	AST_BFT_SHORT: assert property ($past(cfg_q[BIT_BFT])
		&& bus_fault[0] |-> $past(ft_cnt_q[0]) == FT_MAX)
		else $error("short pulse flagged");
	AST_WAKE_WRITE: assert property (seq_cfg_write
		|=> wake_detect_branch_one == $past(rxw_s[BIT_WAKE1]))
		else $error("wake enable not written");
	AST_RXD_OFF: assert property (!cfg_q[BIT_CTRL_IF]
		|=> !ctl_rxd_oe) else $error("receive driver on while disabled");
	AST_TXEN_PASS: assert property (cfg_q[BIT_CTRL_IF] && !txen_s
		|=> !core_tx_en) else $error("transmit enable not passed");
	AST_CLAMP: assert property ((cfg_q[BIT_STUCK] && stuck_on_cascade)
		or !cfg_q[BIT_STUCK] |=> clamp_error == $past(cfg_q[BIT_STUCK]))
		else $error("clamp error wrong");
	AST_RELEASE: assert property (cfg_q[BIT_LATCH] && release_rd[0]
		|=> gen_status_shown == $past(gen_status_live))
		else $error("read did not release latch");
	AST_LIVE: assert property (!cfg_q[BIT_LATCH]
		|=> gen_status_shown == $past(gen_status_live))
		else $error("status not live");
	AST_PARITY: assert property (^rd_word[DATA_W-1:0] == 1'b1)
		else $error("readback parity not odd");
	AST_RSV_ZERO: assert property (seq_cfg_write
		|=> !cfg_q[3] && !cfg_q[0]) else $error("reserved bit written");
	AST_BAD_FRAME: assert property (frame_end && frame_cnt_q != FRAME_BITS
		|=> spi_error && $stable(cfg_q)) else $error("bad frame took effect");
	AST_READ_ONLY: assert property (seq_good_end ##0 rxw_s[BIT_READ_ONLY]
		|=> $stable(cfg_q)) else $error("read-only frame wrote");

endmodule

// ### bench/sccfg_host.sv
// host-side serial master model for the configuration register bench
module sccfg_host (
	input wire logic clk,
	output logic sclk,
	output logic serial_select_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sclk = 1'b0;
		serial_select_n = 1'b1;
		mosi = 1'b0;
	end

	// ==========================================================
	// one frame; n below 16 gives a deliberately short frame
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		sclk = 1'b0;
		#20.3 serial_select_n = 1'b0;
		// data moves on the rising edge, clear of the sampling fall
		for (int i = 15; i > 15 - n; i--) begin
			#62.5 sclk = 1'b1;
			mosi = w[i];
			#62.5 r[i] = miso;
			sclk = 1'b0;
		end
		#62.5 serial_select_n = 1'b1;
		// released line: show the inverse so stale data is never reused
		mosi = ~mosi;
		repeat (10) @(posedge clk);
	endtask
endmodule

// ### bench/sccfg_top_test.sv
// self-checking bench for the star coupler configuration register
module sccfg_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import sccfg_pkg::*;

	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic sclk, serial_select_n, mosi, miso, miso_oe;
	logic [1:0] fault = 2'b00, ncmd = 2'b00, act = 2'b00;
	logic [1:0] quiet, bfault, stk_br = 2'b00;
	logic txd = 1'b1, txen = 1'b0, srxd = 1'b0;
	logic stk_te = 1'b0, stk_cs = 1'b0;
	logic wk1, wk2, ctxd, ctxen, crxd, crxd_oe, casc, clamp, spi_err;
	logic [1:0] trim;
	logic [10:0] st = 11'h000, gsh, b1sh, b2sh;
	int bad_count = 0, total_checks = 0, err_n = 0;
	logic fseen = 1'b0;
	logic oe_seen = 1'b0;
	logic [15:0] r;
	wire logic [15:0] pins = {7'h00, ctxen, wk1, wk2, trim, crxd_oe, casc,
		ctxd, crxd};

	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (spi_err === 1'b1) err_n++;
		if (bfault[0] === 1'b1) fseen = 1'b1;
		if (miso_oe === 1'b1) oe_seen = 1'b1;
	end

	sccfg_host host_u (.clk(clk), .sclk(sclk),
		.serial_select_n(serial_select_n), .mosi(mosi), .miso(miso));

	sccfg_top #(.FAIL_CYC(8)) dut_u (.clk(clk), .nrst(nrst), .sclk(sclk),
		.serial_select_n(serial_select_n), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .branch_tx_fault(fault), .branch_normal_cmd(ncmd),
		.branch_quiet_state(quiet), .bus_active(act), .bus_fault(bfault),
		.wake_detect_branch_one(wk1), .wake_detect_branch_two(wk2),
		.supply_trim(trim), .ctl_txd(txd), .ctl_tx_en(txen),
		.star_rxd(srxd), .core_txd(ctxd), .core_tx_en(ctxen), .ctl_rxd(crxd),
		.ctl_rxd_oe(crxd_oe), .cascade_if_en(casc),
		.stuck_on_tx_enable(stk_te), .stuck_on_cascade(stk_cs),
		.stuck_on_branch(stk_br), .clamp_error(clamp),
		.gen_status_live(st), .br1_status_live(st), .br2_status_live(st),
		.gen_status_shown(gsh), .br1_status_shown(b1sh),
		.br2_status_shown(b2sh), .spi_error(spi_err));

	// ==========================================================
	// checking and access helpers
	task automatic chk(input string nm, input logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [15:0] rword(input logic [10:0] b);
		return {4'h0, b, ~^b};
	endfunction

	task automatic cfg(input logic [11:0] d);
		host_u.xfer({ADDR_CFG, 1'b0, d}, 16, r);
		step(2);
	endtask

	task automatic rdc(input logic [2:0] a, input logic [10:0] e);
		host_u.xfer({a, 1'b1, 12'h000}, 16, r);
		chk("read", r, rword(e));
		step(2);
	endtask

	// ==========================================================
	// watchdog sized well above the expected run of about 40 us
	initial begin
		#200000;
		bad_count++;
		test_done();
	end

	initial begin
		step(10);
		nrst = 1'b1;
		step(4);
		chk("pins", pins, 16'h01F7);
		chk("miso_oe", {15'h0, miso_oe}, 16'h0000);
		rdc(ADDR_CFG, 11'h3EA);
		chk("miso_oe", {14'h0, oe_seen, miso_oe}, 16'h0002);
		cfg(12'hFFF);
		rdc(ADDR_CFG, 11'h7FB);
		step(4);
		chk("pins", pins, 16'h00FE);
		txd = 1'b0;
		txen = 1'b1;
		srxd = 1'b1;
		step(6);
		chk("pins", pins, 16'h01FD);
		cfg(12'h000);
		chk("pins", pins, 16'h0103);
		rdc(ADDR_CFG, 11'h000);
		host_u.xfer({ADDR_CFG, 1'b1, 12'hFFF}, 16, r);
		chk("ro_frame", r, rword(11'h000));
		rdc(ADDR_CFG, 11'h000);
		host_u.xfer({ADDR_CFG, 1'b0, 12'hFFF}, 15, r);
		step(2);
		chk("spi_err", 16'(err_n), 16'h0001);
		rdc(ADDR_CFG, 11'h000);
		rdc(3'h5, 11'h000);
		// clamp detection
		stk_cs = 1'b1;
		step(3);
		chk("clamp", {15'h0, clamp}, 16'h0000);
		cfg(12'h004);
		for (int i = 0; i < 4; i++) begin
			{stk_te, stk_cs, stk_br} = 4'b0001 << i;
			step(3);
			chk("clamp", {15'h0, clamp}, 16'h0001);
		end
		{stk_te, stk_cs, stk_br} = 4'b0000;
		step(3);
		chk("clamp", {15'h0, clamp}, 16'h0000);
		// error confinement
		fault = 2'b01;
		step(4);
		chk("quiet", {14'h0, quiet}, 16'h0000);
		fault = 2'b00;
		cfg(12'h804);
		fault = 2'b10;
		step(4);
		chk("quiet", {14'h0, quiet}, 16'h0002);
		fault = 2'b00;
		ncmd = 2'b10;
		step(1);
		ncmd = 2'b00;
		step(3);
		chk("quiet", {14'h0, quiet}, 16'h0000);
		// failure timer: short pulse passes only with timer off
		act = 2'b01;
		step(4);
		act = 2'b00;
		step(6);
		chk("fault_off", {15'h0, fseen}, 16'h0001);
		cfg(12'hC04);
		fseen = 1'b0;
		act = 2'b01;
		step(4);
		act = 2'b00;
		step(6);
		chk("fault_short", {15'h0, fseen}, 16'h0000);
		act = 2'b01;
		step(16);
		chk("fault_long", {14'h0, bfault}, 16'h0001);
		act = 2'b00;
		// status latching
		cfg(12'h000);
		st = 11'h155;
		step(3);
		chk("live", {5'h0, gsh}, 16'h0155);
		st = 11'h000;
		step(3);
		chk("live", {5'h0, gsh}, 16'h0000);
		cfg(12'h002);
		st = 11'h001;
		step(2);
		st = 11'h000;
		step(3);
		chk("latched", {5'h0, gsh}, 16'h0001);
		rdc(ADDR_GEN, 11'h001);
		chk("released", {5'h0, gsh}, 16'h0000);
		chk("held", {5'h0, b1sh}, 16'h0001);
		rdc(ADDR_BR1, 11'h001);
		chk("released", {5'h0, b1sh}, 16'h0000);
		chk("held", {5'h0, b2sh}, 16'h0001);
		rdc(ADDR_BR2, 11'h001);
		chk("released", {5'h0, b2sh}, 16'h0000);
		test_done();
	end
endmodule
